// file: mdc_config_regs.sv
// Configuration register bank with AXI4-Lite slave and scan plan decode

// Behaviour
// R1: Bit 39 red immunity select, resets one
// R2: Bit 40 green immunity select, resets one
// R3: Bit 41 blue immunity select, resets one
// R4: Bit 42 caps subperiods at 256, resets zero
// R5: Bits 45-43 panel size code, resets 111b
// R6: 48x48 codes 010b/011b set scan order
// R7: 48x64 codes 100b/101b set scan order
// R8: 64x64 codes 110b/111b set scan order
// R9: Bit 47 power-save enable, resets zero
// R10: Word three thresholds blue, green, red from 47
// R11: Reserved bits read zero, writes ignored
module mdc_config_regs #(
    parameter int ADDR_W = 8,
    parameter int SUBP_W = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [mdc_pkg::MDC_DATA_W-1:0] s_axi_wdata,
    input wire logic [mdc_pkg::MDC_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [mdc_pkg::MDC_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [SUBP_W-1:0] subperiod_request,
    output logic [SUBP_W-1:0] subperiod_effective,
    output mdc_pkg::mdc_cw2_type cw2_fields,
    output mdc_pkg::mdc_cw3_type cw3_fields,
    output mdc_pkg::mdc_plan_type scan_plan
);
    import mdc_pkg::*;

    // Refuse geometries the decode and the clamp cannot serve
    if (ADDR_W < 6) begin : g_bad_addr
        $error("ADDR_W must be at least 6");
    end
    if (SUBP_W < 9) begin : g_bad_subp
        $error("SUBP_W must hold the value 256");
    end

    localparam logic [SUBP_W-1:0] SUBP_CAP = SUBP_W'(MDC_SUBP_LIMIT);

    // Word decode: mapped flag from byte offset, upper bits must be zero
    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [4:0] low;
        low = addr[4:0];
        is_mapped = (addr[ADDR_W-1:5] == '0) && (low[1:0] == 2'h0)
            && (low <= MDC_OFS_PLAN);
    endfunction

    // Byte-lane merge of a 16-bit upper half
    function automatic logic [15:0] merge_hi(input logic [15:0] old,
            input logic [MDC_DATA_W-1:0] data,
            input logic [MDC_STRB_W-1:0] strb);
        merge_hi[7:0] = strb[0] ? data[7:0] : old[7:0];
        merge_hi[15:8] = strb[1] ? data[15:8] : old[15:8];
    endfunction

    // Size code to devices, reversal and scan order
    function automatic mdc_plan_type decode_plan(input logic [2:0] code);
        mdc_plan_type p;
        p = '0;
        unique case (code)
            3'h0: p.device_count = 3'h1;
            3'h1: begin
                p.device_count = 3'h2;
                p.scan_order = {2'h0, 2'h0, 2'h1, 2'h0};
            end
            3'h2: begin
                p.device_count = 3'h3;
                p.reverse_mask = 4'h4;
                p.scan_order = {2'h0, 2'h2, 2'h1, 2'h0};
            end
            3'h3: begin
                p.device_count = 3'h3;
                p.reverse_mask = 4'h4;
                p.scan_order = {2'h0, 2'h1, 2'h2, 2'h0};
            end
            3'h4: begin
                p.device_count = 3'h3;
                p.reverse_mask = 4'hc;
                p.scan_order = {2'h0, 2'h2, 2'h1, 2'h0};
            end
            3'h5: begin
                p.device_count = 3'h3;
                p.reverse_mask = 4'hc;
                p.scan_order = {2'h0, 2'h1, 2'h2, 2'h0};
            end
            3'h6: begin
                p.device_count = 3'h4;
                p.reverse_mask = 4'hc;
                p.scan_order = {2'h3, 2'h2, 2'h1, 2'h0};
            end
            3'h7: begin
                p.device_count = 3'h4;
                p.reverse_mask = 4'hc;
                p.scan_order = {2'h2, 2'h1, 2'h3, 2'h0};
            end
        endcase
        return p;
    endfunction

    // Upper halves as software sees them; unlisted bits stay zero
    function automatic logic [15:0] cw2_hi_image(input mdc_cw2_type f);
        cw2_hi_image = '0;
        cw2_hi_image[MDC_CW2_RED_POS-MDC_HI_BASE] = f.red_group_noise_select;
        cw2_hi_image[MDC_CW2_GREEN_POS-MDC_HI_BASE] =
            f.green_group_noise_select;
        cw2_hi_image[MDC_CW2_BLUE_POS-MDC_HI_BASE] = f.blue_group_noise_select;
        cw2_hi_image[MDC_CW2_SUBP_POS-MDC_HI_BASE] = f.subperiod_limit_enable;
        cw2_hi_image[MDC_CW2_SIZE_POS-MDC_HI_BASE +: 3] = f.panel_size_code;
        cw2_hi_image[MDC_CW2_PSAVE_POS-MDC_HI_BASE] =
            f.matrix_power_save_enable;
    endfunction

    function automatic logic [15:0] cw3_hi_image(input mdc_cw3_type f);
        cw3_hi_image = '0;
        cw3_hi_image[MDC_CW3_RED_POS-MDC_HI_BASE +: 3] = f.red_short_threshold;
        cw3_hi_image[MDC_CW3_GREEN_POS-MDC_HI_BASE +: 3] =
            f.green_short_threshold;
        cw3_hi_image[MDC_CW3_BLUE_POS-MDC_HI_BASE +: 3] =
            f.blue_short_threshold;
    endfunction
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [MDC_DATA_W-1:0] w_data;
    logic [MDC_STRB_W-1:0] w_strb;
    logic do_write;
    logic [15:0] next_cw2_hi;
    logic [15:0] next_cw3_hi;
    logic [MDC_DATA_W-1:0] next_rdata;

    // Address and data may arrive in either order; each is parked alone
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    // Wait for the previous response so only one write is ever open
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Write response; unmapped offsets answer SLVERR and change nothing
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= MDC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(aw_addr) ? MDC_RESP_OKAY : MDC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Merged images; only named fields are kept, so reserved writes vanish
    assign next_cw2_hi = merge_hi(cw2_hi_image(cw2_fields), w_data, w_strb);
    assign next_cw3_hi = merge_hi(cw3_hi_image(cw3_fields), w_data, w_strb);

    // Function control word two, upper fields
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cw2_fields.red_group_noise_select <= MDC_RST_NOISE; // R1
            cw2_fields.green_group_noise_select <= MDC_RST_NOISE; // R2
            cw2_fields.blue_group_noise_select <= MDC_RST_NOISE; // R3
            cw2_fields.subperiod_limit_enable <= MDC_RST_SUBP; // R4
            cw2_fields.panel_size_code <= MDC_RST_SIZE; // R5
            cw2_fields.matrix_power_save_enable <= MDC_RST_PSAVE; // R9
        end else if (do_write && aw_addr == ADDR_W'(MDC_OFS_CW2_HI)) begin
            cw2_fields.red_group_noise_select <=
                next_cw2_hi[MDC_CW2_RED_POS-MDC_HI_BASE]; // R1
            cw2_fields.green_group_noise_select <=
                next_cw2_hi[MDC_CW2_GREEN_POS-MDC_HI_BASE]; // R2
            cw2_fields.blue_group_noise_select <=
                next_cw2_hi[MDC_CW2_BLUE_POS-MDC_HI_BASE]; // R3
            cw2_fields.subperiod_limit_enable <=
                next_cw2_hi[MDC_CW2_SUBP_POS-MDC_HI_BASE]; // R4
            cw2_fields.panel_size_code <=
                next_cw2_hi[MDC_CW2_SIZE_POS-MDC_HI_BASE +: 3]; // R5
            cw2_fields.matrix_power_save_enable <=
                next_cw2_hi[MDC_CW2_PSAVE_POS-MDC_HI_BASE]; // R9
        end
    end

    // Function control word three, short-detection thresholds
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cw3_fields <= {3{MDC_RST_THRESH}}; // R10
        end else if (do_write && aw_addr == ADDR_W'(MDC_OFS_CW3_HI)) begin
            cw3_fields.red_short_threshold <=
                next_cw3_hi[MDC_CW3_RED_POS-MDC_HI_BASE +: 3]; // R10
            cw3_fields.green_short_threshold <=
                next_cw3_hi[MDC_CW3_GREEN_POS-MDC_HI_BASE +: 3]; // R10
            cw3_fields.blue_short_threshold <=
                next_cw3_hi[MDC_CW3_BLUE_POS-MDC_HI_BASE +: 3]; // R10
        end
    end

    // Plan follows the size code combinationally from the stored field
    assign scan_plan = decode_plan(cw2_fields.panel_size_code); // R6 R7 R8

    // Ceiling is applied only while the option is on
    always_comb begin
        if (cw2_fields.subperiod_limit_enable
                && subperiod_request > SUBP_CAP) begin
            subperiod_effective = SUBP_CAP; // R4
        end else begin
            subperiod_effective = subperiod_request;
        end
    end

    // Read mux; lower halves hold no fields here and read as zero
    always_comb begin
        next_rdata = '0;
        if (s_axi_araddr == ADDR_W'(MDC_OFS_CW2_HI)) begin
            next_rdata[15:0] = cw2_hi_image(cw2_fields); // R11
        end else if (s_axi_araddr == ADDR_W'(MDC_OFS_CW3_HI)) begin
            next_rdata[15:0] = cw3_hi_image(cw3_fields); // R10
        end else if (s_axi_araddr == ADDR_W'(MDC_OFS_PLAN)) begin
            next_rdata[2:0] = scan_plan.device_count;
            next_rdata[7:4] = scan_plan.reverse_mask;
            next_rdata[15:8] = scan_plan.scan_order;
            next_rdata[16] = cw2_fields.subperiod_limit_enable;
        end
    end

    // Read channel; data held from a flop until rready
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= MDC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? MDC_RESP_OKAY
                : MDC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    logic cw2_hi_write;
    assign cw2_hi_write = do_write && aw_addr == ADDR_W'(MDC_OFS_CW2_HI);

    property p_red_write;
        cw2_hi_write && w_strb[0] |=> cw2_fields.red_group_noise_select
            == $past(w_data[MDC_CW2_RED_POS-MDC_HI_BASE]);
    endproperty
    a_red_write: assert property (p_red_write) // R1
        else $error("red noise select did not take written bit");

    property p_green_reset;
        $rose(reset_n) |-> cw2_fields.green_group_noise_select == 1'b1;
    endproperty
    a_green_reset: assert property (p_green_reset) // R2
        else $error("green noise select not one after reset");

    property p_blue_hold;
        !cw2_hi_write |=> $stable(cw2_fields.blue_group_noise_select);
    endproperty
    a_blue_hold: assert property (p_blue_hold) // R3
        else $error("blue noise select changed without a write");

    property p_subp_cap;
        cw2_fields.subperiod_limit_enable |->
            subperiod_effective <= SUBP_CAP
            && (subperiod_request > SUBP_CAP
            || subperiod_effective == subperiod_request);
    endproperty
    a_subp_cap: assert property (p_subp_cap) // R4
        else $error("subperiod ceiling not applied");

    property p_size_write;
        cw2_hi_write && w_strb[1] |=> cw2_fields.panel_size_code
            == $past(w_data[MDC_CW2_SIZE_POS-MDC_HI_BASE +: 3]);
    endproperty
    a_size_write: assert property (p_size_write) // R5
        else $error("panel size code did not take written value");

    property p_plan_48;
        cw2_fields.panel_size_code == 3'h3 |-> scan_plan.device_count == 3'h3
            && scan_plan.scan_order[2:1] == {2'h1, 2'h2};
    endproperty
    a_plan_48: assert property (p_plan_48) // R6
        else $error("48x48 swapped order wrong");

    property p_plan_4864;
        cw2_fields.panel_size_code == 3'h4 |->
            scan_plan.reverse_mask == 4'hc
            && scan_plan.scan_order[2:0] == {2'h2, 2'h1, 2'h0};
    endproperty
    a_plan_4864: assert property (p_plan_4864) // R7
        else $error("48x64 plan wrong");

    property p_plan_64;
        cw2_fields.panel_size_code == 3'h7 |-> scan_plan.device_count == 3'h4
            && scan_plan.scan_order == {2'h2, 2'h1, 2'h3, 2'h0};
    endproperty
    a_plan_64: assert property (p_plan_64) // R8
        else $error("64x64 swapped order wrong");

    property p_psave_write;
        cw2_hi_write && w_strb[1] ##1 !cw2_hi_write |=>
            cw2_fields.matrix_power_save_enable
            == $past(w_data[MDC_CW2_PSAVE_POS-MDC_HI_BASE], 2);
    endproperty
    a_psave_write: assert property (p_psave_write) // R9
        else $error("power save enable lost its written value");

    property p_cw3_read;
        s_axi_arvalid && s_axi_arready
            && s_axi_araddr == ADDR_W'(MDC_OFS_CW3_HI) |=>
            s_axi_rvalid && s_axi_rdata[15:7] == $past(cw3_fields)
            && s_axi_rdata[6:0] == 7'h0;
    endproperty
    a_cw3_read: assert property (p_cw3_read) // R10
        else $error("word three readback misplaced");

    property p_reserved_zero;
        s_axi_arvalid && s_axi_arready
            && s_axi_araddr == ADDR_W'(MDC_OFS_CW2_HI) |=>
            s_axi_rdata[6:0] == 7'h0 && s_axi_rdata[14] == 1'b0
            && s_axi_rdata[31:16] == 16'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // R11
        else $error("reserved bits of word two not zero");

endmodule

// file: mdc_pkg.sv
// Package for the matrix driver configuration register bank
package mdc_pkg;

    // Bus geometry
    localparam int MDC_DATA_W = 32;
    localparam int MDC_STRB_W = MDC_DATA_W / 8;

    // Byte offsets of the software-visible words
    localparam logic [4:0] MDC_OFS_CW2_LO = 5'h00;
    localparam logic [4:0] MDC_OFS_CW2_HI = 5'h04;
    localparam logic [4:0] MDC_OFS_CW3_LO = 5'h08;
    localparam logic [4:0] MDC_OFS_CW3_HI = 5'h0c;
    localparam logic [4:0] MDC_OFS_PLAN = 5'h10;

    // Bit positions inside the 48-bit words
    localparam int MDC_HI_BASE = 32;
    localparam int MDC_CW2_RED_POS = 39;
    localparam int MDC_CW2_GREEN_POS = 40;
    localparam int MDC_CW2_BLUE_POS = 41;
    localparam int MDC_CW2_SUBP_POS = 42;
    localparam int MDC_CW2_SIZE_POS = 43;
    localparam int MDC_CW2_PSAVE_POS = 47;
    localparam int MDC_CW3_RED_POS = 39;
    localparam int MDC_CW3_GREEN_POS = 42;
    localparam int MDC_CW3_BLUE_POS = 45;

    // Reset values
    localparam logic MDC_RST_NOISE = 1'b1;
    localparam logic MDC_RST_SUBP = 1'b0;
    localparam logic [2:0] MDC_RST_SIZE = 3'h7;
    localparam logic MDC_RST_PSAVE = 1'b0;
    localparam logic [2:0] MDC_RST_THRESH = 3'h0;

    // Subperiod ceiling while the limit option is on
    localparam int MDC_SUBP_LIMIT = 256;

    // AXI responses
    localparam logic [1:0] MDC_RESP_OKAY = 2'h0;
    localparam logic [1:0] MDC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic matrix_power_save_enable;
        logic [2:0] panel_size_code;
        logic subperiod_limit_enable;
        logic blue_group_noise_select;
        logic green_group_noise_select;
        logic red_group_noise_select;
    } mdc_cw2_type;

    typedef struct packed {
        logic [2:0] blue_short_threshold;
        logic [2:0] green_short_threshold;
        logic [2:0] red_short_threshold;
    } mdc_cw3_type;

    // Decoded scan plan: devices in use, reversed ones, visiting order
    typedef struct packed {
        logic [2:0] device_count;
        logic [3:0] reverse_mask;
        logic [3:0][1:0] scan_order;
    } mdc_plan_type;

endpackage

// file: mdc_config_regs_tb_top.sv
// Self-checking bench for the configuration register bank
`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end

module mdc_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mdc_pkg::*;

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [15:0] subperiod_request = 16'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] subperiod_effective;
    mdc_cw2_type cw2_fields;
    mdc_cw3_type cw3_fields;
    mdc_plan_type scan_plan;
    // Expected answers, oldest first, as {resp, data}
    logic [33:0] expq[$];
    logic [33:0] note, got;
    // Visible upper halves of the two words
    logic [15:0] m2, m3;
    int mismatches = 0;
    int n_compared = 0;
    int seed = 72925;
    // Plan decode per size code: devices, reversed mask, visit order
    logic [2:0] cnt_tab [8] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4};
    logic [3:0] rev_tab [8] = '{4'h0, 4'h0, 4'h4, 4'h4, 4'hc, 4'hc, 4'hc, 4'hc};
    logic [7:0] ord_tab [8] = '{8'h00, 8'h04, 8'h24, 8'h18,
                                8'h24, 8'h18, 8'he4, 8'h9c};

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    mdc_config_regs #(.ADDR_W(8), .SUBP_W(16)) i_mdc_config_regs (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .subperiod_request(subperiod_request),
        .subperiod_effective(subperiod_effective),
        .cw2_fields(cw2_fields),
        .cw3_fields(cw3_fields),
        .scan_plan(scan_plan)
    );

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One AXI transfer; ready sampled mid-cycle, so the edge acts on it
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] er, input logic [31:0] ed);
        logic aw_hs, w_hs, ar_hs, done;
        int i;
        expq.push_back({er, wr ? 32'h0 : ed});
        done = 1'b0;
        @(posedge sys_clk);
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata <= d;
            s_axi_wstrb <= s;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        for (i = 0; i < 50 && !done; i++) begin
            @(negedge sys_clk);
            aw_hs = s_axi_awvalid && s_axi_awready === 1'b1;
            w_hs = s_axi_wvalid && s_axi_wready === 1'b1;
            ar_hs = s_axi_arvalid && s_axi_arready === 1'b1;
            done = wr ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1;
            @(posedge sys_clk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            if (ar_hs) s_axi_arvalid <= 1'b0;
            if (done) s_axi_bready <= 1'b0;
            if (done) s_axi_rready <= 1'b0;
        end
        if (!done) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            report_and_stop;
        end
    endtask

    // Write one visible half and update the model by lane and mask
    task automatic wr_word(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s);
        logic [15:0] lanes;
        lanes = {{8{s[1]}}, {8{s[0]}}};
        lanes = lanes & ((a == 8'h04) ? 16'hbf80 : 16'hff80);
        if (a == 8'h04) m2 = (m2 & ~lanes) | (d[15:0] & lanes);
        else m3 = (m3 & ~lanes) | (d[15:0] & lanes);
        bus(1'b1, a, d, s, MDC_RESP_OKAY, 32'h0);
    endtask

    task automatic check_fields;
        `CHK(cw2_fields, {m2[15], m2[13:7]});
        `CHK(cw3_fields, m3[15:7]);
    endtask

    // Monitor: each response stands one cycle since ready is held high
    always @(negedge sys_clk) begin
        if (s_axi_bvalid === 1'b1 || s_axi_rvalid === 1'b1) begin
            note = (expq.size() > 0) ? expq.pop_front() : 34'h3_ffff_ffff;
            got = s_axi_bvalid ? {s_axi_bresp, 32'h0}
                               : {s_axi_rresp, s_axi_rdata};
            `CHK(got, note);
        end
    end

    initial begin
        logic [31:0] d;
        logic [15:0] req, ex;
        int i, c, lim;
        m2 = 16'h3b80;
        m3 = 16'h0000;
        repeat (12) @(posedge sys_clk);
        check_fields;
        reset_n <= 1'b1;
        bus(1'b0, 8'h04, 32'h0, 4'h0, MDC_RESP_OKAY, {16'h0, m2});
        bus(1'b0, 8'h0c, 32'h0, 4'h0, MDC_RESP_OKAY, 32'h0);
        bus(1'b0, 8'h00, 32'h0, 4'h0, MDC_RESP_OKAY, 32'h0);
        bus(1'b0, 8'h08, 32'h0, 4'h0, MDC_RESP_OKAY, 32'h0);
        $display("reset values test done");
        for (i = 0; i < 40; i++) begin
            d = $random(seed);
            wr_word(d[31] ? 8'h0c : 8'h04, d, d[30:27]);
            check_fields;
            bus(1'b0, 8'h04, 32'h0, 4'h0, MDC_RESP_OKAY, {16'h0, m2});
            bus(1'b0, 8'h0c, 32'h0, 4'h0, MDC_RESP_OKAY, {16'h0, m3});
        end
        $display("random field test done");
        bus(1'b1, 8'h00, 32'hffff_ffff, 4'hf, MDC_RESP_OKAY, 32'h0);
        bus(1'b1, 8'h08, 32'hffff_ffff, 4'hf, MDC_RESP_OKAY, 32'h0);
        bus(1'b1, 8'h10, 32'hffff_ffff, 4'hf, MDC_RESP_OKAY, 32'h0);
        bus(1'b1, 8'h14, 32'hffff_ffff, 4'hf, MDC_RESP_SLVERR, 32'h0);
        bus(1'b1, 8'h84, 32'hffff_ffff, 4'hf, MDC_RESP_SLVERR, 32'h0);
        bus(1'b0, 8'h14, 32'h0, 4'h0, MDC_RESP_SLVERR, 32'h0);
        check_fields;
        $display("ignored access test done");
        // Every size code, limit toggled alongside
        for (c = 0; c < 8; c++) begin
            d = {16'h0, m2};
            d[13:11] = c[2:0];
            d[10] = c[0];
            wr_word(8'h04, d, 4'h3);
            ex = {1'b0, cnt_tab[c], rev_tab[c], ord_tab[c]};
            `CHK(scan_plan, ex[14:0]);
            bus(1'b0, 8'h10, 32'h0, 4'h0, MDC_RESP_OKAY, {15'h0, m2[10],
                ord_tab[c], rev_tab[c], 1'b0, cnt_tab[c]});
        end
        $display("scan plan test done");
        for (lim = 0; lim < 2; lim++) begin
            d = {16'h0, m2};
            d[10] = lim[0];
            wr_word(8'h04, d, 4'h2);
            for (i = 0; i < 12; i++) begin
                req = 16'($random(seed));
                if (i == 0) req = 16'd256;
                if (i == 1) req = 16'd257;
                if (i == 2) req = 16'd255;
                @(posedge sys_clk);
                subperiod_request <= req;
                @(negedge sys_clk);
                ex = (lim == 1 && req > 16'd256) ? 16'd256 : req;
                `CHK(subperiod_effective, ex);
            end
        end
        $display("subperiod limit test done");
        // Reset in mid-run restores every field
        @(posedge sys_clk);
        reset_n <= 1'b0;
        m2 = 16'h3b80;
        m3 = 16'h0000;
        @(negedge sys_clk);
        check_fields;
        @(posedge sys_clk);
        reset_n <= 1'b1;
        bus(1'b0, 8'h04, 32'h0, 4'h0, MDC_RESP_OKAY, {16'h0, m2});
        `CHK(expq.size(), 0);
        $display("second reset test done");
        report_and_stop;
    end
endmodule
